/* hdl/utx_pkg.sv */
package utx_pkg;

  // Register byte offsets on the Avalon slave
  localparam logic [5:0] OFS_THR = 6'h00;
  localparam logic [5:0] OFS_DLL = 6'h04;
  localparam logic [5:0] OFS_DLM = 6'h08;
  localparam logic [5:0] OFS_IER = 6'h0c;
  localparam logic [5:0] OFS_ISR = 6'h10;
  localparam logic [5:0] OFS_FCR = 6'h14;
  localparam logic [5:0] OFS_LCR = 6'h18;
  localparam logic [5:0] OFS_MCR = 6'h1c;
  localparam logic [5:0] OFS_LSR = 6'h20;

  // Field positions
  localparam int FCR_EN    = 0;
  localparam int FCR_TXRST = 2;
  localparam int FCR_BLOCK = 3;
  localparam int IER_THRE  = 1;
  localparam int MCR_PRESC = 7;
  localparam int LCR_BREAK = 6;
  localparam int LSR_DR    = 0;
  localparam int LSR_THRE  = 5;
  localparam int LSR_TEMT  = 6;

  // Values after reset and fixed codes
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_DIV      = 16'h0000;
  localparam logic [3:0]  ISR_NONE     = 4'h1;
  localparam logic [3:0]  ISR_THRE     = 4'h2;
  localparam logic [1:0]  ISR_FIFO_ON  = 2'h3;

  // Cycle counts
  localparam logic [3:0] BIT_LAST_TICK = 4'hf;  // 16 sample ticks a bit
  localparam logic [1:0] PRESC_LAST    = 2'h3;  // Divide by four

  // Transmit sequencer states
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } utx_tx_state_t;

  // Character format, laid out as line control bits 5..0
  typedef struct packed {
    logic       stick;
    logic       even;
    logic       par_en;
    logic       two_stop;
    logic [1:0] wlen;
  } utx_frame_t;

endpackage : utx_pkg

/* hdl/utx_mem.sv */
module utx_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 16,
  parameter int ADDR_W = 4
) (
  // Clock
  input  wire logic              clk,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read side, data one cycle after address
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : utx_mem

/* hdl/utx_channel.sv */
// Function
// - Single mode: receive ready low while data waits
// - Block mode: falls at trigger/timeout, rises when empty
// - Single mode: transmit ready low only when empty
// - Block mode: transmit ready low unless FIFO full
// - FIFO control bit 3 selects block mode
// - Per-channel divider, 16-bit divisor, 16x tick
// - Divisor held in low and high bytes
// - One bit per sixteen sample ticks
// - Start, data, optional parity, stop bits
// - Least significant data bit goes first
// - Holding writes push the 16-entry FIFO
// - Non-FIFO: holding empty set on transfer
// - Non-FIFO: holding empty raises enabled interrupt
// - Non-FIFO: transmitter empty when shifter drained
// - FIFO mode: holding empty while FIFO empty
// - FIFO mode: empty FIFO raises enabled interrupt
// - FIFO mode: transmitter empty needs both empty
// - Register access needs no serial clock
// - One oscillator clock feeds the divider
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
module utx_channel #(
  parameter int FIFO_DEPTH = 16,
  parameter int ADDR_W     = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Receive path status
  input  wire logic [4:0]  rx_level,
  input  wire logic        rx_trig_hit,
  input  wire logic        rx_timeout,
  // Serial side and block-transfer pins
  output logic             serial_out,
  output logic             sample16_tick,
  output logic             rx_block_ready_n,
  output logic             tx_block_ready_n,
  output logic             tx_irq
);

  localparam int CW = ADDR_W + 1;

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            div_low;
    logic [7:0]            div_high;
    logic [3:0]            irq_enable_reg;
    logic                  fifo_en;
    logic                  block;
    logic [7:0]            lcr;
    logic [7:0]            modem_control_reg;
    logic [ADDR_W-1:0]     wptr;
    logic [ADDR_W-1:0]     rptr;
    logic [CW-1:0]         count;
    logic                  ld_pend;
    logic [1:0]            pre_cnt;
    logic [15:0]           baud_cnt;
    logic                  tick;
    utx_pkg::utx_tx_state_t state;
    logic [3:0]            tick_cnt;
    logic [2:0]            bit_idx;
    logic                  stop2;
    logic [7:0]            shift;
    logic                  par;
    logic                  txd;
    logic                  irq;
    logic                  thre_seen;
    logic                  rx_rdy_n;
  } utx_core_t;

  utx_core_t s;
  utx_core_t n;

  logic              req;
  logic              acc;
  logic              wr_en;
  logic [7:0]        wd;
  logic              wr_thr;
  logic              wr_fcr;
  logic              rd_isr;
  logic [15:0]       divisor;
  logic [CW-1:0]     limit;
  logic              full;
  logic              push;
  logic              pop;
  logic              fifo_clr;
  logic              thre;
  logic              temt;
  logic              stage_en;
  logic              bit_end;
  logic [7:0]        rd_data;
  logic [7:0]        mask;
  logic [7:0]        isr_val;
  logic [7:0]        lsr_val;
  logic [31:0]       rmux;
  utx_pkg::utx_frame_t fmt;

  // Bus decode; write lands at the edge where waitrequest is low
  assign req      = avs_read | avs_write;
  assign acc      = req & s.ack;
  assign wr_en    = acc & avs_write & avs_byteenable[0];
  assign wd       = avs_writedata[7:0];
  assign wr_thr   = wr_en & (avs_address == utx_pkg::OFS_THR);
  assign wr_fcr   = wr_en & (avs_address == utx_pkg::OFS_FCR);
  assign rd_isr   = acc & avs_read & (avs_address == utx_pkg::OFS_ISR);
  assign fmt      = utx_pkg::utx_frame_t'(s.lcr[5:0]);

  // Divisor from two bytes, one oscillator clock
  assign divisor  = {s.div_high, s.div_low};
  assign stage_en = ~s.modem_control_reg[utx_pkg::MCR_PRESC] | (s.pre_cnt == utx_pkg::PRESC_LAST);

  // Queue depth: sixteen with FIFO on, one holding byte otherwise
  assign limit    = s.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
  assign full     = (s.count == limit);
  assign push     = wr_thr & ~full;
  assign pop      = (s.state == utx_pkg::TX_IDLE) & ~s.ld_pend & (s.count != '0);
  assign fifo_clr = wr_fcr & ((wd[utx_pkg::FCR_EN] != s.fifo_en) | wd[utx_pkg::FCR_TXRST]);

  // Transmit status flags
  assign thre     = (s.count == '0) & ~s.ld_pend;
  assign temt     = thre & (s.state == utx_pkg::TX_IDLE);
  assign bit_end  = s.tick & (s.tick_cnt == utx_pkg::BIT_LAST_TICK);
  assign mask     = 8'hff >> (2'h3 - fmt.wlen);

  // Read values of the status registers
  assign isr_val  = {s.fifo_en ? utx_pkg::ISR_FIFO_ON : 2'h0, 2'h0,
                     s.irq ? utx_pkg::ISR_THRE : utx_pkg::ISR_NONE};
  assign lsr_val  = {1'b0, temt, thre, 4'h0, rx_level != 5'h00};

  // Read multiplexer, bus needs no serial timing
  always_comb begin
    rmux = 32'h0000_0000;
    case (avs_address)
      utx_pkg::OFS_DLL: rmux[7:0] = s.div_low;
      utx_pkg::OFS_DLM: rmux[7:0] = s.div_high;
      utx_pkg::OFS_IER: rmux[3:0] = s.irq_enable_reg;
      utx_pkg::OFS_ISR: rmux[7:0] = isr_val;
      utx_pkg::OFS_FCR: rmux[7:0] = {4'h0, s.block, 2'h0, s.fifo_en};
      utx_pkg::OFS_LCR: rmux[7:0] = s.lcr;
      utx_pkg::OFS_MCR: rmux[7:0] = s.modem_control_reg;
      utx_pkg::OFS_LSR: rmux[7:0] = lsr_val;
      default:          rmux      = 32'h0000_0000;
    endcase
  end

  // Transmit queue storage
  utx_mem #(
    .DATA_W (8),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (ADDR_W)
  ) u_txq (
    .clk     (core_clk),
    .wr_en   (push),
    .wr_addr (s.wptr),
    .wr_data (wd),
    .rd_addr (s.rptr),
    .rd_data (rd_data)
  );

  // Next-state logic for the whole channel
  always_comb begin
    n = s;
    // Bus: one wait state, read data captured as waitrequest drops
    n.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      n.rdata = avs_read ? rmux : 32'h0000_0000;
    end
    if (wr_en) begin
      case (avs_address)
        utx_pkg::OFS_DLL: n.div_low  = wd;
        utx_pkg::OFS_DLM: n.div_high = wd;
        utx_pkg::OFS_IER: n.irq_enable_reg      = wd[3:0];
        utx_pkg::OFS_LCR: n.lcr      = wd;
        utx_pkg::OFS_MCR: n.modem_control_reg      = wd;
        utx_pkg::OFS_FCR: begin
          n.fifo_en = wd[utx_pkg::FCR_EN];
          n.block   = wd[utx_pkg::FCR_BLOCK];
        end
        default: n.lcr = s.lcr;
      endcase
    end
    // Queue pointers and fill count
    if (push) begin
      n.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr    = s.rptr + 1'b1;
      n.ld_pend = 1'b1;
    end else begin
      n.ld_pend = 1'b0;
    end
    case ({push, pop})
      2'b10:   n.count = s.count + CW'(1);
      2'b01:   n.count = s.count - CW'(1);
      default: n.count = s.count;
    endcase
    if (fifo_clr) begin
      n.wptr  = '0;
      n.rptr  = '0;
      n.count = '0;
    end
    // Baud divider: optional quarter stage, then divisor
    n.pre_cnt = s.pre_cnt + 2'h1;
    n.tick    = 1'b0;
    if (stage_en && divisor != 16'h0000) begin
      if (s.baud_cnt >= divisor - 16'h0001) begin
        n.baud_cnt = 16'h0000;
        n.tick     = 1'b1;
      end else begin
        n.baud_cnt = s.baud_cnt + 16'h0001;
      end
    end
    // Transmit sequencer, one bit per sixteen ticks
    if (s.tick) begin
      n.tick_cnt = s.tick_cnt + 4'h1;
    end
    case (s.state)
      utx_pkg::TX_IDLE: begin
        if (s.ld_pend) begin
          n.shift    = rd_data;
          n.tick_cnt = 4'h0;
          n.stop2    = 1'b0;
          n.par      = fmt.stick ? ~fmt.even : (^(rd_data & mask) ^ ~fmt.even);
          n.state    = utx_pkg::TX_START;
        end
      end
      utx_pkg::TX_START: begin
        if (bit_end) begin
          n.bit_idx = 3'h0;
          n.state   = utx_pkg::TX_DATA;
        end
      end
      utx_pkg::TX_DATA: begin
        if (bit_end) begin
          n.shift   = {1'b0, s.shift[7:1]};
          n.bit_idx = s.bit_idx + 3'h1;
          if (s.bit_idx == {1'b1, fmt.wlen}) begin
            n.state = fmt.par_en ? utx_pkg::TX_PAR : utx_pkg::TX_STOP;
          end
        end
      end
      utx_pkg::TX_PAR: begin
        if (bit_end) begin
          n.state = utx_pkg::TX_STOP;
        end
      end
      utx_pkg::TX_STOP: begin
        if (bit_end) begin
          if (fmt.two_stop && !s.stop2) begin
            n.stop2 = 1'b1;
          end else begin
            n.state = utx_pkg::TX_IDLE;
          end
        end
      end
      default: n.state = utx_pkg::TX_IDLE;
    endcase
    // Line level follows the next state
    case (n.state)
      utx_pkg::TX_START: n.txd = 1'b0;
      utx_pkg::TX_DATA:  n.txd = n.shift[0];
      utx_pkg::TX_PAR:   n.txd = n.par;
      default:           n.txd = 1'b1;
    endcase
    if (s.lcr[utx_pkg::LCR_BREAK]) begin
      n.txd = 1'b0;
    end
    // Holding-empty interrupt; a new set beats a clear
    n.thre_seen = thre & s.irq_enable_reg[utx_pkg::IER_THRE];
    if (thre && s.irq_enable_reg[utx_pkg::IER_THRE] && !s.thre_seen) begin
      n.irq = 1'b1;
    end else if (rd_isr || wr_thr || !s.irq_enable_reg[utx_pkg::IER_THRE]) begin
      n.irq = 1'b0;
    end
    // Receive ready pin
    if (!(s.fifo_en && s.block)) begin
      n.rx_rdy_n = (rx_level == 5'h00);
    end else if (rx_level == 5'h00) begin
      n.rx_rdy_n = 1'b1;
    end else if (rx_trig_hit || rx_timeout) begin
      n.rx_rdy_n = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s          <= '0;
      s.rdata    <= 32'h0000_0000;
      s.div_low  <= utx_pkg::RST_DIV[7:0];
      s.div_high <= utx_pkg::RST_DIV[15:8];
      s.lcr      <= utx_pkg::RST_BYTE;
      s.modem_control_reg      <= utx_pkg::RST_BYTE;
      s.state    <= utx_pkg::TX_IDLE;
      s.txd      <= 1'b1;
      s.rx_rdy_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign avs_readdata     = s.rdata;
  assign avs_waitrequest  = req & ~s.ack;
  assign serial_out       = s.txd;
  assign sample16_tick    = s.tick;
  assign rx_block_ready_n = s.rx_rdy_n;
  assign tx_block_ready_n = (s.fifo_en && s.block) ? full : ~thre;
  assign tx_irq           = s.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence seq_bit_end_in(utx_pkg::utx_tx_state_t st);
    s.state == st && bit_end;
  endsequence

  sequence seq_load;
    s.ld_pend && s.count == '0 && !push;
  endsequence

  AST_RX_BLOCK_READY_N_SINGLE: assert property (!(s.fifo_en && s.block) && rx_level != 5'h00 |=> !rx_block_ready_n)
    else $error("receive ready not low with data waiting");
  AST_RX_BLOCK_READY_N_BLOCK: assert property (s.fifo_en && s.block && rx_level != 5'h00 && !rx_trig_hit && !rx_timeout
                                    && rx_block_ready_n && !wr_fcr |=> rx_block_ready_n)
    else $error("receive ready fell without trigger or timeout");
  AST_TX_BLOCK_READY_N_SINGLE: assert property (!(s.fifo_en && s.block) && s.count != '0 |-> tx_block_ready_n)
    else $error("transmit ready low while bytes queued");
  AST_TX_BLOCK_READY_N_BLOCK: assert property (s.fifo_en && s.block |-> tx_block_ready_n == (s.count == CW'(FIFO_DEPTH)))
    else $error("transmit ready wrong in block mode");
  AST_BAUD_DIV: assert property (s.tick && divisor == 16'h0003 && !s.modem_control_reg[utx_pkg::MCR_PRESC] && !wr_en ##1 !wr_en
                                 |-> !s.tick ##1 !s.tick ##1 s.tick)
    else $error("tick spacing does not match divisor");
  AST_PRESC: assert property (s.tick && divisor == 16'h0001 && s.modem_control_reg[utx_pkg::MCR_PRESC] && !wr_en
                              |=> !s.tick [*3] ##1 s.tick)
    else $error("prescaler does not divide by four");
  AST_BIT_TIME: assert property ($changed(s.state) && $past(s.state) != utx_pkg::TX_IDLE
                                 |-> $past(bit_end))
    else $error("bit ended off a sixteen tick boundary");
  AST_START_DATA: assert property (seq_bit_end_in(utx_pkg::TX_START) |=> s.state == utx_pkg::TX_DATA
                                   && serial_out == (s.shift[0] & !s.lcr[utx_pkg::LCR_BREAK]))
    else $error("first data bit is not bit zero after start");
  AST_START_LOW: assert property (s.state == utx_pkg::TX_START |-> !serial_out)
    else $error("start bit not low");
  AST_PUSH: assert property (push && !pop && !fifo_clr |=> s.count == $past(s.count) + CW'(1))
    else $error("holding write did not grow the queue");
  AST_THRE_LOAD: assert property (seq_load |-> lsr_val[utx_pkg::LSR_THRE] == 1'b0
                                  ##1 lsr_val[utx_pkg::LSR_THRE])
    else $error("holding empty not set on transfer");
  AST_IRQ: assert property ($rose(thre) && s.irq_enable_reg[utx_pkg::IER_THRE] && s.thre_seen == 1'b0 |=> tx_irq)
    else $error("holding empty interrupt missing");
  AST_TEMT: assert property (lsr_val[utx_pkg::LSR_TEMT] |-> s.count == '0 && s.state == utx_pkg::TX_IDLE)
    else $error("transmitter empty with data left");

endmodule : utx_channel

/* testbench/utx_line_rx.sv */
// Serial line receiver on the far side of the transmit pin
module utx_line_rx (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Line and sampling clock
  input  wire logic        serial_out,
  input  wire logic        sample16_tick,
  // Character format, line control bits 5..0
  input  wire logic [5:0]  lcr_fmt,
  // Captured frame, bit 0 is the start bit
  output logic      [11:0] frame_bits,
  output logic             rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  int   tcnt;
  int   total;
  logic busy;

  // Bits in one frame: start, data, parity, stops
  always_comb begin
    total = 7 + int'(lcr_fmt[1:0]) + int'(lcr_fmt[3]) + int'(lcr_fmt[2]);
  end

  // Start on falling line, sample mid-bit every 16 ticks
  always @(posedge core_clk) begin
    rx_valid <= 1'b0;
    if (srst) begin
      busy <= 1'b0;
    end else if (!busy) begin
      if (serial_out == 1'b0) begin
        busy       <= 1'b1;
        tcnt       <= 0;
        frame_bits <= '0;
      end
    end else if (sample16_tick) begin
      tcnt <= tcnt + 1;
      if (tcnt % 16 == 7) begin
        frame_bits[tcnt / 16] <= serial_out;
        if (tcnt / 16 == total - 1) begin
          busy     <= 1'b0;
          rx_valid <= 1'b1;
        end
      end
    end
  end
endmodule : utx_line_rx

/* testbench/tb_top.sv */
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  rx_level = 5'h00;
  logic        rx_trig_hit = 1'b0;
  logic        rx_timeout = 1'b0;
  logic        serial_out;
  logic        sample16_tick;
  logic        rx_block_ready_n;
  logic        tx_block_ready_n;
  logic        tx_irq;
  logic [5:0]  lcr_cur = 6'h00;
  logic [11:0] frame_bits;
  logic        rx_valid;
  logic [11:0] exp_q[$];
  logic [11:0] got_q[$];
  logic [31:0] r;
  logic [7:0]  d;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          g;

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  utx_channel uut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_level(rx_level),
    .rx_trig_hit(rx_trig_hit), .rx_timeout(rx_timeout), .serial_out(serial_out),
    .sample16_tick(sample16_tick), .rx_block_ready_n(rx_block_ready_n),
    .tx_block_ready_n(tx_block_ready_n), .tx_irq(tx_irq));

  utx_line_rx line_rx (.core_clk(core_clk), .srst(srst), .serial_out(serial_out),
    .sample16_tick(sample16_tick), .lcr_fmt(lcr_cur), .frame_bits(frame_bits), .rx_valid(rx_valid));

  // Collect decoded frames
  always @(posedge core_clk) begin
    if (rx_valid) begin
      got_q.push_back(frame_bits);
    end
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("Error %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d errors", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Avalon write, held until waitrequest sampled low
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, v};
    avs_write     <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
  endtask : bus_wr

  // Avalon read, data taken at the accepting edge
  task automatic bus_rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // Cycles between two sampling ticks
  task automatic tick_gap(output int n);
    n = 0;
    @(posedge core_clk);
    while (sample16_tick !== 1'b1) @(posedge core_clk);
    do begin
      @(posedge core_clk);
      n++;
    end while (sample16_tick !== 1'b1 && n < 1000);
  endtask : tick_gap

  // Expected line bits of one character
  function automatic logic [11:0] frame_of(input logic [7:0] v, input logic [5:0] f);
    int          n;
    logic [7:0]  dm;
    logic        p;
    logic [11:0] fr;
    n  = 5 + int'(f[1:0]);
    dm = v & (8'hff >> (8 - n));
    p  = f[5] ? ~f[4] : (f[4] ? ^dm : ~^dm);
    fr = '1;
    fr[0] = 1'b0;
    for (int i = 0; i < n; i++) fr[1 + i] = dm[i];
    if (f[3]) fr[1 + n] = p;
    for (int i = 2 + n + int'(f[3]) + int'(f[2]); i < 12; i++) fr[i] = 1'b0;
    return fr;
  endfunction : frame_of

  // Wait for all queued characters, compare in order
  task automatic wait_frames();
    logic [11:0] a;
    logic [11:0] b;
    while (got_q.size() < exp_q.size()) @(posedge core_clk);
    while (exp_q.size() > 0) begin
      a = got_q.pop_front();
      b = exp_q.pop_front();
      `CHK(a, b)
    end
  endtask : wait_frames

  // Queue one random character
  task automatic send_one();
    d = 8'($urandom);
    exp_q.push_back(frame_of(d, lcr_cur));
    bus_wr(utx_pkg::OFS_THR, d);
  endtask : send_one

  // Drive receive status, check the ready pin two edges later
  task automatic rxset(input logic [4:0] l, input logic t, input logic o, input logic e);
    @(posedge core_clk);
    rx_level    <= l;
    rx_trig_hit <= t;
    rx_timeout  <= o;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(rx_block_ready_n, e)
  endtask : rxset

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    void'($urandom(32'h5d0e));
    @(posedge core_clk);
    #1;
    `CHK({serial_out, tx_block_ready_n, rx_block_ready_n, tx_irq}, 4'b1010)
    bus_rd(utx_pkg::OFS_LSR, r);
    `CHK(r, 32'h00000060)
    bus_rd(utx_pkg::OFS_ISR, r);
    `CHK(r, 32'h00000001)
    bus_rd(6'h3c, r);
    `CHK(r, 32'h00000000)
    // Write without byte lane 0 is ignored
    avs_byteenable <= 4'he;
    bus_wr(utx_pkg::OFS_DLM, 8'h5a);
    avs_byteenable <= 4'hf;
    bus_rd(utx_pkg::OFS_DLM, r);
    `CHK(r, 32'h00000000)
    // Divisor bytes and prescaler
    bus_wr(utx_pkg::OFS_DLL, 8'h03);
    bus_wr(utx_pkg::OFS_DLM, 8'h00);
    tick_gap(g);
    `CHK(g, 3)
    bus_wr(utx_pkg::OFS_DLM, 8'h01);
    tick_gap(g);
    tick_gap(g);
    `CHK(g, 259)
    bus_wr(utx_pkg::OFS_DLM, 8'h00);
    bus_wr(utx_pkg::OFS_DLL, 8'h01);
    bus_wr(utx_pkg::OFS_MCR, 8'h80);
    tick_gap(g);
    tick_gap(g);
    `CHK(g, 4)
    bus_wr(utx_pkg::OFS_MCR, 8'h00);
    bus_wr(utx_pkg::OFS_IER, 8'h02);
    // Single-character modes, FIFO off then on
    for (int m = 0; m < 2; m++) begin
      bus_wr(utx_pkg::OFS_FCR, 8'(m));
      for (int k = 0; k < 3; k++) begin
        lcr_cur = 6'($urandom);
        bus_wr(utx_pkg::OFS_LCR, {2'b00, lcr_cur});
        send_one();
        #1;
        `CHK(tx_block_ready_n, 1'b1)
        bus_rd(utx_pkg::OFS_LSR, r);
        `CHK(r[6], 1'b0)
        wait_frames();
        do bus_rd(utx_pkg::OFS_LSR, r); while (r[6] !== 1'b1);
        `CHK(r, 32'h00000060)
        `CHK(tx_block_ready_n, 1'b0)
        `CHK(tx_irq, 1'b1)
        bus_rd(utx_pkg::OFS_ISR, r);
        `CHK(r, (m == 1) ? 32'h000000c2 : 32'h00000002)
      end
    end
    // Block mode, fill the FIFO to full
    bus_wr(utx_pkg::OFS_DLL, 8'h01);
    bus_wr(utx_pkg::OFS_FCR, 8'h09);
    lcr_cur = 6'($urandom);
    bus_wr(utx_pkg::OFS_LCR, {2'b00, lcr_cur});
    for (int i = 0; i < 17; i++) begin
      send_one();
      #1;
      `CHK(tx_block_ready_n, (i == 16))
    end
    bus_rd(utx_pkg::OFS_LSR, r);
    `CHK(r[6:5], 2'b00)
    do bus_rd(utx_pkg::OFS_LSR, r); while (r[5] !== 1'b1);
    `CHK(r[6], 1'b0)
    `CHK(tx_irq, 1'b1)
    wait_frames();
    do bus_rd(utx_pkg::OFS_LSR, r); while (r[6] !== 1'b1);
    `CHK(r, 32'h00000060)
    bus_rd(utx_pkg::OFS_ISR, r);
    `CHK(r, 32'h000000c2)
    // Transmit reset drops queued bytes, shifter finishes
    send_one();
    bus_wr(utx_pkg::OFS_THR, 8'($urandom));
    bus_wr(utx_pkg::OFS_THR, 8'($urandom));
    bus_wr(utx_pkg::OFS_FCR, 8'h0d);
    bus_rd(utx_pkg::OFS_LSR, r);
    `CHK(r[6:5], 2'b01)
    wait_frames();
    // Receive ready pin, single then block mode
    bus_wr(utx_pkg::OFS_FCR, 8'h01);
    rxset(5'h00, 1'b0, 1'b0, 1'b1);
    rxset(5'(1 + $urandom % 16), 1'b0, 1'b0, 1'b0);
    bus_wr(utx_pkg::OFS_FCR, 8'h09);
    rxset(5'h00, 1'b0, 1'b0, 1'b1);
    rxset(5'h05, 1'b0, 1'b0, 1'b1);
    rxset(5'h08, 1'b1, 1'b0, 1'b0);
    rxset(5'h07, 1'b0, 1'b0, 1'b0);
    rxset(5'h00, 1'b0, 1'b0, 1'b1);
    rxset(5'h03, 1'b0, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
